// ==== pkg/wdg_cfg.svh ====
// Purpose: register layout, reset values and field positions of the watchdog block
// Assumes: included by the package and by the design modules
// Notes: indices are word indices; the bus byte address is four times the index
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define WDG_CTRL_INDEX 32'h00FF_FFB1
`define WDG_CNT_INDEX 32'h00FF_FFB2

// ----------------------------------------
// Control/status field positions
// ----------------------------------------
`define WDG_CWE_WI_BIT 7
`define WDG_CWE_BIT 6
`define WDG_MWE_WI_BIT 5
`define WDG_MWE_BIT 4
`define WDG_RUN_WI_BIT 3
`define WDG_RUN_BIT 2
`define WDG_FLAG_WI_BIT 1
`define WDG_FLAG_BIT 0

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define WDG_CTRL_RESET 8'hAE
`define WDG_CNT_WIDTH 8
`define WDG_CNT_RESET 8'h00
`define WDG_CNT_MAX 8'hFF

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define WDG_RESP_OKAY 2'b00
`define WDG_RESP_DECERR 2'b11

`endif

// ==== pkg/wdg_pkg.sv ====
// Purpose: shared types of the watchdog block
// Assumes: wdg_cfg.svh on the include path
// Notes: bus structs keep the published AXI4-Lite signal names
`include "wdg_cfg.svh"

package wdg_pkg;

  // ----------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } wdg_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdg_axi_rsp_t;

  // ----------------------------------------
  // Stored control bits
  // ----------------------------------------
  typedef struct packed {
    logic counterWriteEnable;
    logic masterWriteEnable;
    logic watchdogRun;
    logic watchdogResetFlag;
  } wdg_ctrl_t;

  // ----------------------------------------
  // Module state
  // ----------------------------------------
  typedef struct packed {
    logic pinSync1;
    logic pinSync2;
    wdg_ctrl_t ctrl;
    logic awHeld;
    logic [31:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    wdg_axi_rsp_t rsp;
    logic watchdogResetOut;
  } wdg_top_state_t;

  typedef struct packed {
    logic [`WDG_CNT_WIDTH-1:0] count;
  } wdg_cnt_state_t;

endpackage : wdg_pkg

// ==== rtl/wdg_counter.sv ====
// Purpose: up-counting watchdog counter with load and overflow
// Assumes: one clock, synchronous active-high reset
// Notes: overflow is a same-cycle flag of the wrap from max to zero
`include "wdg_cfg.svh"

module wdg_counter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic run,
  input wire logic loadEn,
  input wire logic [`WDG_CNT_WIDTH-1:0] loadValue,
  // Status
  output logic [`WDG_CNT_WIDTH-1:0] count,
  output logic overflow
);

  wdg_pkg::wdg_cnt_state_t state_reg;
  wdg_pkg::wdg_cnt_state_t state_next;

  // Wrap flag; a load or clear in the same cycle takes priority
  assign overflow = run && !loadEn && !clear && (state_reg.count == `WDG_CNT_MAX);
  assign count = state_reg.count;

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (clear) begin
      state_next.count = `WDG_CNT_RESET;
    end else if (loadEn) begin
      state_next.count = loadValue;
    end else if (run) begin
      state_next.count = state_reg.count + `WDG_CNT_WIDTH'(1);
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg.count <= `WDG_CNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : wdg_counter

// ==== rtl/wdg_top.sv ====
// Purpose: watchdog control/status register with guarded bits, AXI4-Lite slave
// Assumes: 25 MHz clk_sys, synchronous active-high reset, one clock domain
// Notes: counter advances one step per clock while the run bit is set
`include "wdg_cfg.svh"

module wdg_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // External reset pin, active low, asynchronous
  input wire logic extResetPinN,
  // Register bus
  input wire wdg_pkg::wdg_axi_req_t axiReq,
  output wdg_pkg::wdg_axi_rsp_t axiRsp,
  // Watchdog outputs
  output logic watchdogResetOut,
  output logic watchdogRunOut
);

  // ----------------------------------------
  // Byte addresses of the registers
  // ----------------------------------------
  localparam logic [31:0] CtrlAddr = `WDG_CTRL_INDEX << 2;
  localparam logic [31:0] CntAddr = `WDG_CNT_INDEX << 2;
  localparam logic [7:0] CtrlReset = `WDG_CTRL_RESET;

  wdg_pkg::wdg_top_state_t state_reg;
  wdg_pkg::wdg_top_state_t state_next;

  // Counter hookup
  logic [`WDG_CNT_WIDTH-1:0] cntValue;
  logic cntOverflow;
  logic cntClear;
  logic cntLoad;
  logic [`WDG_CNT_WIDTH-1:0] cntLoadValue;

  // Bus decode helpers
  logic awTake;
  logic wTake;
  logic arTake;
  logic haveAw;
  logic haveW;
  logic doWrite;
  logic [31:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrCtrl;
  logic wrCnt;
  logic pinReset;
  logic [7:0] ctrlRead;

  // ----------------------------------------
  // Outputs straight from state flops
  // ----------------------------------------
  assign axiRsp = state_reg.rsp;
  assign watchdogResetOut = state_reg.watchdogResetOut;
  assign watchdogRunOut = state_reg.ctrl.watchdogRun;

  // Pin level after the two-flop synchroniser
  assign pinReset = !state_reg.pinSync2;

  // ----------------------------------------
  // Readback image of the control register
  // ----------------------------------------
  always_comb begin
    ctrlRead = 8'h00;
    ctrlRead[`WDG_CWE_WI_BIT] = 1'b1;
    ctrlRead[`WDG_MWE_WI_BIT] = 1'b1;
    ctrlRead[`WDG_RUN_WI_BIT] = 1'b1;
    ctrlRead[`WDG_FLAG_WI_BIT] = 1'b1;
    ctrlRead[`WDG_CWE_BIT] = state_reg.ctrl.counterWriteEnable;
    ctrlRead[`WDG_MWE_BIT] = state_reg.ctrl.masterWriteEnable;
    ctrlRead[`WDG_RUN_BIT] = state_reg.ctrl.watchdogRun;
    ctrlRead[`WDG_FLAG_BIT] = state_reg.ctrl.watchdogResetFlag;
  end

  // ----------------------------------------
  // Write channel handshakes
  // ----------------------------------------
  always_comb begin
    awTake = axiReq.awvalid && state_reg.rsp.awready;
    wTake = axiReq.wvalid && state_reg.rsp.wready;
    arTake = axiReq.arvalid && state_reg.rsp.arready;
    haveAw = state_reg.awHeld || awTake;
    haveW = state_reg.wHeld || wTake;
    // Response slot must be free before the write lands
    doWrite = haveAw && haveW && !state_reg.rsp.bvalid;
    wrAddr = state_reg.awHeld ? state_reg.awAddr : axiReq.awaddr;
    wrData = state_reg.wHeld ? state_reg.wData : axiReq.wdata;
    wrStrb = state_reg.wHeld ? state_reg.wStrb : axiReq.wstrb;
    // Low two address bits ignored, word access only
    wrCtrl = doWrite && (wrAddr[31:2] == CtrlAddr[31:2]);
    wrCnt = doWrite && (wrAddr[31:2] == CntAddr[31:2]);
  end

  // ----------------------------------------
  // Counter control
  // ----------------------------------------
  always_comb begin
    // Both reset sources restart the count from zero
    cntClear = pinReset || state_reg.watchdogResetOut;
    cntLoad = wrCnt && wrStrb[0] && state_reg.ctrl.counterWriteEnable;
    cntLoadValue = wrData[`WDG_CNT_WIDTH-1:0];
  end

  wdg_counter u_counter (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(cntClear),
    .run(state_reg.ctrl.watchdogRun),
    .loadEn(cntLoad),
    .loadValue(cntLoadValue),
    .count(cntValue),
    .overflow(cntOverflow)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;

    // Synchroniser for the reset pin
    state_next.pinSync1 = extResetPinN;
    state_next.pinSync2 = state_reg.pinSync1;

    // Internal reset is a one-cycle pulse
    state_next.watchdogResetOut = 1'b0;

    // Write address and data may arrive in either order
    if (awTake) begin
      state_next.awHeld = 1'b1;
      state_next.awAddr = axiReq.awaddr;
    end
    if (wTake) begin
      state_next.wHeld = 1'b1;
      state_next.wData = axiReq.wdata;
      state_next.wStrb = axiReq.wstrb;
    end

    // Control register write; each bit on its own gate
    if (wrCtrl && wrStrb[0]) begin
      if (!wrData[`WDG_CWE_WI_BIT]) begin
        state_next.ctrl.counterWriteEnable = wrData[`WDG_CWE_BIT];
      end
      if (!wrData[`WDG_MWE_WI_BIT]) begin
        state_next.ctrl.masterWriteEnable = wrData[`WDG_MWE_BIT];
      end
      if (state_reg.ctrl.masterWriteEnable) begin
        if (!wrData[`WDG_RUN_WI_BIT]) begin
          state_next.ctrl.watchdogRun = wrData[`WDG_RUN_BIT];
        end
        if (!wrData[`WDG_FLAG_WI_BIT] && !wrData[`WDG_FLAG_BIT]) begin
          state_next.ctrl.watchdogResetFlag = 1'b0;
        end
      end
    end

    // Write response; gated bits never raise an error
    if (doWrite) begin
      state_next.awHeld = 1'b0;
      state_next.wHeld = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = (wrCtrl || wrCnt) ? `WDG_RESP_OKAY : `WDG_RESP_DECERR;
    end else if (state_reg.rsp.bvalid && axiReq.bready) begin
      state_next.rsp.bvalid = 1'b0;
    end
    // Accept a new beat only when nothing waits
    state_next.rsp.awready = !state_next.awHeld && !state_next.rsp.bvalid;
    state_next.rsp.wready = !state_next.wHeld && !state_next.rsp.bvalid;

    // Read path answers one cycle after the address
    if (arTake) begin
      state_next.rsp.arready = 1'b0;
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rresp = `WDG_RESP_OKAY;
      if (axiReq.araddr[31:2] == CtrlAddr[31:2]) begin
        state_next.rsp.rdata = {24'h00_0000, ctrlRead};
      end else if (axiReq.araddr[31:2] == CntAddr[31:2]) begin
        state_next.rsp.rdata = {{(32 - `WDG_CNT_WIDTH){1'b0}}, cntValue};
      end else begin
        state_next.rsp.rdata = 32'h0000_0000;
        state_next.rsp.rresp = `WDG_RESP_DECERR;
      end
    end else if (state_reg.rsp.rvalid && axiReq.rready) begin
      state_next.rsp.rvalid = 1'b0;
      state_next.rsp.arready = 1'b1;
    end

    if (cntOverflow) begin
      state_next.watchdogResetOut = 1'b1;
    end
    // Internal reset reloads control; flag kept set
    if (state_reg.watchdogResetOut) begin
      state_next.ctrl.counterWriteEnable = CtrlReset[`WDG_CWE_BIT];
      state_next.ctrl.masterWriteEnable = CtrlReset[`WDG_MWE_BIT];
      state_next.ctrl.watchdogRun = CtrlReset[`WDG_RUN_BIT];
    end
    // Set wins over a same-cycle software clear
    if (cntOverflow || state_reg.watchdogResetOut) begin
      state_next.ctrl.watchdogResetFlag = 1'b1;
    end

    // pin reset reloads every control bit from the reset image, flag too
    if (pinReset) begin
      state_next.ctrl.counterWriteEnable = CtrlReset[`WDG_CWE_BIT];
      state_next.ctrl.masterWriteEnable = CtrlReset[`WDG_MWE_BIT];
      state_next.ctrl.watchdogRun = CtrlReset[`WDG_RUN_BIT];
      state_next.ctrl.watchdogResetFlag = CtrlReset[`WDG_FLAG_BIT];
      state_next.watchdogResetOut = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // reset image 0xae, running
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg.pinSync1 <= 1'b1;
      state_reg.pinSync2 <= 1'b1;
      state_reg.ctrl.counterWriteEnable <= CtrlReset[`WDG_CWE_BIT];
      state_reg.ctrl.masterWriteEnable <= CtrlReset[`WDG_MWE_BIT];
      state_reg.ctrl.watchdogRun <= CtrlReset[`WDG_RUN_BIT];
      state_reg.ctrl.watchdogResetFlag <= CtrlReset[`WDG_FLAG_BIT];
      state_reg.awHeld <= 1'b0;
      state_reg.awAddr <= 32'h0000_0000;
      state_reg.wHeld <= 1'b0;
      state_reg.wData <= 32'h0000_0000;
      state_reg.wStrb <= 4'h0;
      state_reg.rsp.awready <= 1'b1;
      state_reg.rsp.wready <= 1'b1;
      state_reg.rsp.bvalid <= 1'b0;
      state_reg.rsp.bresp <= `WDG_RESP_OKAY;
      state_reg.rsp.arready <= 1'b1;
      state_reg.rsp.rvalid <= 1'b0;
      state_reg.rsp.rdata <= 32'h0000_0000;
      state_reg.rsp.rresp <= `WDG_RESP_OKAY;
      state_reg.watchdogResetOut <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : wdg_top

// ==== sim/test_watchdog_guarded_control.sv ====
// Purpose: self-checking bench of wdg_top
// Assumes: wdg_cfg.svh on the include path
// Notes: overflow is reached once by loading the counter near its top, once free-running
`include "wdg_cfg.svh"

module test_watchdog_guarded_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTRL = `WDG_CTRL_INDEX * 4;
  localparam logic [31:0] CNT = `WDG_CNT_INDEX * 4;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic extResetPinN = 1'b1;
  wdg_pkg::wdg_axi_req_t axiReq = '0;
  wdg_pkg::wdg_axi_rsp_t axiRsp;
  logic watchdogResetOut;
  logic watchdogRunOut;
  logic sawPulse = 1'b0;
  logic [31:0] rd;
  logic [31:0] hold;
  logic [1:0] rsp;
  int miscompares = 0;
  int nTests = 0;
  int cycles = 0;

  wdg_top dut_u (.clk_sys(clk_sys), .reset(reset), .extResetPinN(extResetPinN),
    .axiReq(axiReq), .axiRsp(axiRsp), .watchdogResetOut(watchdogResetOut),
    .watchdogRunOut(watchdogRunOut));

  // Clock, 40 ns period
  always #20 clk_sys = ~clk_sys;

  // Sticky pulse record and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (watchdogResetOut === 1'b1) sawPulse <= 1'b1;
    if (cycles == 3000) begin
      miscompares++;
      endOfTest();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Write: address and data offered together, bready held until bvalid
  task automatic axiWrite(input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= addr;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= data;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    rsp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [31:0] addr);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= addr;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1);
    rd = axiRsp.rdata;
    rsp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : axiRead

  task automatic ctrlIs(input logic [31:0] exp);
    axiRead(CTRL);
    check("control", exp, rd);
  endtask : ctrlIs

  // Inhibited writes change nothing; then master enable and halt
  task automatic scnGuards();
    ctrlIs(32'h0000_00AE);
    axiWrite(CTRL, 32'h0000_00FF);
    ctrlIs(32'h0000_00AE);
    axiWrite(CTRL, 32'h0000_00F3);
    check("write answer", {30'b0, `WDG_RESP_OKAY}, {30'b0, rsp});
    ctrlIs(32'h0000_00AE);
    axiWrite(CTRL, 32'h0000_009A);
    ctrlIs(32'h0000_00BE);
    axiWrite(CTRL, 32'h0000_00FA);
    ctrlIs(32'h0000_00BE);
    axiWrite(CTRL, 32'h0000_00F2);
    ctrlIs(32'h0000_00BA);
    check("run output", 32'h0000_0000, {31'b0, watchdogRunOut});
  endtask : scnGuards

  // Halted counter holds; loads need the counter enable
  task automatic scnCounter();
    axiRead(CNT);
    hold = rd;
    repeat (5) @(posedge clk_sys);
    axiWrite(CNT, 32'h0000_0055);
    axiRead(CNT);
    check("held counter", hold, rd);
    axiWrite(CTRL, 32'h0000_007F);
    ctrlIs(32'h0000_00FA);
    axiWrite(CNT, 32'h0000_00FD);
    axiRead(CNT);
    check("loaded counter", 32'h0000_00FD, rd);
  endtask : scnCounter

  // Restart near the top: overflow pulses and leaves the flag set
  task automatic scnOverflow();
    sawPulse <= 1'b0;
    axiWrite(CTRL, 32'h0000_00F6);
    for (int i = 0; i < 40 && !sawPulse; i++) @(posedge clk_sys);
    check("reset pulse", 32'h0000_0001, {31'b0, sawPulse});
    ctrlIs(32'h0000_00AF);
  endtask : scnOverflow

  // Flag clears only with master enable and its inhibit low
  task automatic scnFlagClear();
    axiWrite(CTRL, 32'h0000_00FC);
    ctrlIs(32'h0000_00AF);
    axiWrite(CTRL, 32'h0000_009A);
    axiWrite(CTRL, 32'h0000_00FE);
    ctrlIs(32'h0000_00BF);
    axiWrite(CTRL, 32'h0000_00FC);
    ctrlIs(32'h0000_00BE);
  endtask : scnFlagClear

  // Free-running overflow, then the pin clears the flag
  task automatic scnPinReset();
    // Let the clear land before the loop tests the old pulse record
    sawPulse <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 400 && !sawPulse; i++) @(posedge clk_sys);
    ctrlIs(32'h0000_00AF);
    extResetPinN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    extResetPinN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ctrlIs(32'h0000_00AE);
  endtask : scnPinReset

  // Unmapped place answers decode error and changes nothing
  task automatic scnUnmapped();
    axiRead(32'h0000_0010);
    check("read answer", {30'b0, `WDG_RESP_DECERR}, {30'b0, rsp});
    axiWrite(32'h0000_0010, 32'h0000_0000);
    check("write answer", {30'b0, `WDG_RESP_DECERR}, {30'b0, rsp});
    ctrlIs(32'h0000_00AE);
  endtask : scnUnmapped

  task automatic endOfTest();
    if (miscompares == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : endOfTest

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    scnGuards();
    scnCounter();
    scnOverflow();
    scnFlagClear();
    scnPinReset();
    scnUnmapped();
    endOfTest();
  end
endmodule : test_watchdog_guarded_control

// ==== sim/wdg_top_asserts.sv ====
// Purpose: port checker of wdg_top
// Assumes: one clock, sync active-high reset
// Notes: bound at the foot of this file
`include "wdg_cfg.svh"

module wdg_top_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic extResetPinN,
  // Bus and outputs
  input wire wdg_pkg::wdg_axi_req_t axiReq,
  input wire wdg_pkg::wdg_axi_rsp_t axiRsp,
  input wire logic watchdogResetOut,
  input wire logic watchdogRunOut
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTRL = `WDG_CTRL_INDEX * 4;
  localparam logic [31:0] CNT = `WDG_CNT_INDEX * 4;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Bus takes
  wire wTake = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
  wire arTake = axiReq.arvalid && axiRsp.arready;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  reset_values_a: assert property ($fell(reset) |-> watchdogRunOut && axiRsp.arready)
    else $error("run or ready wrong after reset");
  pulse_single_a: assert property (watchdogResetOut |=> !watchdogResetOut)
    else $error("internal reset longer than one cycle");
  pulse_reload_a: assert property (watchdogResetOut |-> ##2 watchdogRunOut)
    else $error("run not reloaded after internal reset");
  run_stop_a: assert property ($fell(watchdogRunOut) |->
    axiRsp.bvalid || $past(axiRsp.bvalid))
    else $error("run fell without a write");
  run_guard_a: assert property (wTake && axiReq.awaddr == CTRL && axiReq.wdata[3]
    |=> $stable(watchdogRunOut) ##1 $stable(watchdogRunOut))
    else $error("run changed with inhibit set");
  ctrl_read_a: assert property (arTake && axiReq.araddr == CTRL |=> axiRsp.rvalid
    && axiRsp.rdata[7] && axiRsp.rdata[5] && axiRsp.rdata[3] && axiRsp.rdata[1])
    else $error("inhibit bit read as zero");
  unmapped_read_a: assert property (arTake && axiReq.araddr != CTRL && axiReq.araddr != CNT
    |=> axiRsp.rresp == `WDG_RESP_DECERR && axiRsp.rdata == 32'h0000_0000)
    else $error("unmapped read answer wrong");
  write_answer_a: assert property (wTake |=> axiRsp.bvalid && !axiRsp.awready)
    else $error("write answer late");
endmodule : wdg_top_asserts

bind wdg_top wdg_top_asserts chk_u (.clk_sys(clk_sys), .reset(reset),
  .extResetPinN(extResetPinN), .axiReq(axiReq), .axiRsp(axiRsp),
  .watchdogResetOut(watchdogResetOut), .watchdogRunOut(watchdogRunOut));
